// ### inc/ocmp_defs.vh
// Constants for the output compare unit: offsets, fields, resets, modes
`ifndef OCMP_DEFS_VH
`define OCMP_DEFS_VH
`define OCMP_ADDR_CTRL      4'h0
`define OCMP_ADDR_PRI       4'h1
`define OCMP_ADDR_SEC       4'h2
`define OCMP_ADDR_PER2      4'h3
`define OCMP_ADDR_PER3      4'h4
`define OCMP_ADDR_TMR2      4'h5
`define OCMP_ADDR_TMR3      4'h6
`define OCMP_ADDR_STAT      4'h7
`define OCMP_ADDR_TCTL      4'h8
`define OCMP_MODE_LSB       0
`define OCMP_MODE_MSB       2
`define OCMP_TSEL_BIT       3
`define OCMP_FLT_BIT        4
`define OCMP_CTRL_RST       16'h0000
`define OCMP_CMP_RST        16'h0000
`define OCMP_PER_RST        16'hFFFF
`define OCMP_MODE_OFF       3'h0
`define OCMP_MODE_OS_LO     3'h1
`define OCMP_MODE_OS_HI     3'h2
`define OCMP_MODE_TOGGLE    3'h3
`define OCMP_MODE_DLY_OS    3'h4
`define OCMP_MODE_CONT      3'h5
`define OCMP_MODE_PWM       3'h6
`define OCMP_MODE_PWM_FLT   3'h7
`endif

// ### hw/ocmp_timer.v
// Free-running up counter with period wrap, used as a compare time base
`timescale 1ns/1ps
`include "ocmp_defs.vh"
module ocmp_timer (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire        run_i,
	input  wire        per_we_i,
	input  wire [15:0] per_wdata_i,
	output reg  [15:0] count_o,
	output reg  [15:0] period_o,
	output reg         wrap_o
);
	always @(posedge clock_i) begin
		if (rst_i) begin
			count_o  <= 16'h0000;
			period_o <= `OCMP_PER_RST;
			wrap_o   <= 1'b0;
		end else begin
			if (per_we_i)
				period_o <= per_wdata_i;
			wrap_o <= 1'b0;
			if (run_i) begin
				if (count_o == period_o) begin
					count_o <= 16'h0000;
					wrap_o  <= 1'b1;
				end else begin
					count_o <= count_o + 16'h0001;
				end
			end
		end
	end
endmodule // ocmp_timer

// ### hw/ocmp_unit.v
// Output compare unit with two time bases, plain register port and one output pin
`timescale 1ns/1ps
`include "ocmp_defs.vh"
module ocmp_unit #(
	parameter [3:0] UNIT_NUM = 4'h1
) (
	input  wire        clock_i,
	input  wire        rst_i,
	input  wire [3:0]  addr_i,
	input  wire [15:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [15:0] rdata_o,
	input  wire        fault_in_a_i,
	input  wire        fault_in_b_i,
	input  wire        gpio_level_i,
	output reg         compare_out_o,
	output reg         compare_out_oe_n_o,
	output reg         compare_irq_flag_o,
	output reg         fault_flag_o
);
	reg  [2:0]  mode_q;
	reg         tsel_q;
	reg  [15:0] pri_q;
	reg  [15:0] sec_q;
	reg         pin_q;
	reg         done_q;
	reg         armed_q;
	reg         seen_q;
	reg         fault_q;
	reg  [1:0]  run_q;
	reg         fa_s1_q;
	reg         fa_s2_q;
	reg         fb_s1_q;
	reg         fb_s2_q;
	reg         flt_prev_q;
	reg  [15:0] last_cnt_q;
	reg         last_ok_q;
	wire [15:0] cnt2;
	wire [15:0] cnt3;
	wire [15:0] per2;
	wire [15:0] per3;
	wire        wrap2;
	wire        wrap3;
	wire        ctrl_wr;
	wire [15:0] cnt;
	wire        wrap;
	wire        new_cnt;
	wire        pri_hit;
	wire        sec_hit;
	wire        flt_lvl;
	wire        flt_fall;
	wire        flt_set;
	reg         pin_d;
	reg         done_d;
	reg         flag_d;

	// Decoding shared by all register write strobes; readback decodes addr_i in its own case
	function hit;
		input [3:0] a;
		input [3:0] b;
		input       s;
		begin
			hit = s && (a == b);
		end
	endfunction

	function is_pwm;
		input [2:0] m;
		begin
			is_pwm = (m == `OCMP_MODE_PWM) || (m == `OCMP_MODE_PWM_FLT);
		end
	endfunction

	assign ctrl_wr = hit(addr_i, `OCMP_ADDR_CTRL, wr_i);

	ocmp_timer u_tmr2 (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.run_i      (run_q[0]),
		.per_we_i   (hit(addr_i, `OCMP_ADDR_PER2, wr_i)),
		.per_wdata_i(wdata_i),
		.count_o    (cnt2),
		.period_o   (per2),
		.wrap_o     (wrap2)
	);

	ocmp_timer u_tmr3 (
		.clock_i    (clock_i),
		.rst_i      (rst_i),
		.run_i      (run_q[1]),
		.per_we_i   (hit(addr_i, `OCMP_ADDR_PER3, wr_i)),
		.per_wdata_i(wdata_i),
		.count_o    (cnt3),
		.period_o   (per3),
		.wrap_o     (wrap3)
	);

	assign cnt  = tsel_q ? cnt3 : cnt2;
	assign wrap = tsel_q ? wrap3 : wrap2;

	// One event per count value; a stalled timer cannot repeat a match
	assign new_cnt = !last_ok_q || (cnt != last_cnt_q);
	// A zero primary compare is skipped until the counter has moved once after enable
	assign pri_hit = new_cnt && (cnt == pri_q) && (pri_q != 16'h0000 || seen_q);
	assign sec_hit = new_cnt && (cnt == sec_q);

	// Fault pins are asynchronous, so both are synchronised before use
	assign flt_lvl  = (UNIT_NUM <= 4'h4) ? fa_s2_q : fb_s2_q;
	assign flt_fall = flt_prev_q && !flt_lvl;
	assign flt_set  = (mode_q == `OCMP_MODE_PWM_FLT) && flt_fall && !fault_q;

	always @* begin
		pin_d  = pin_q;
		done_d = done_q;
		flag_d = 1'b0;
		case (mode_q)
			`OCMP_MODE_OS_LO: begin
				if (pri_hit && !done_q) begin
					pin_d  = 1'b1;
					done_d = 1'b1;
					flag_d = 1'b1;
				end
			end
			`OCMP_MODE_OS_HI: begin
				if (pri_hit && !done_q) begin
					pin_d  = 1'b0;
					done_d = 1'b1;
					flag_d = 1'b1;
				end
			end
			`OCMP_MODE_TOGGLE: begin
				if (pri_hit) begin
					pin_d  = !pin_q;
					flag_d = 1'b1;
				end
			end
			`OCMP_MODE_DLY_OS, `OCMP_MODE_CONT: begin
				if (!done_q) begin
					if (pri_hit && !pin_q) begin
						pin_d = 1'b1;
					end else if (sec_hit && pin_q) begin
						pin_d  = 1'b0;
						flag_d = 1'b1;
						// Delayed one-shot halts here until re-armed
						done_d = (mode_q == `OCMP_MODE_DLY_OS);
					end
				end
			end
			`OCMP_MODE_PWM, `OCMP_MODE_PWM_FLT: begin
				if (wrap)
					pin_d = (sec_q != 16'h0000);
				else if (new_cnt && cnt == pri_q)
					pin_d = 1'b0;
			end
			default: begin
				pin_d = pin_q;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (rst_i) begin
			mode_q             <= `OCMP_MODE_OFF;
			tsel_q             <= 1'b0;
			pri_q              <= `OCMP_CMP_RST;
			sec_q              <= `OCMP_CMP_RST;
			pin_q              <= 1'b0;
			done_q             <= 1'b0;
			armed_q            <= 1'b0;
			seen_q             <= 1'b0;
			fault_q            <= 1'b0;
			run_q              <= 2'b00;
			fa_s1_q            <= 1'b1;
			fa_s2_q            <= 1'b1;
			fb_s1_q            <= 1'b1;
			fb_s2_q            <= 1'b1;
			flt_prev_q         <= 1'b1;
			last_cnt_q         <= 16'h0000;
			last_ok_q          <= 1'b0;
			rdata_o            <= 16'h0000;
			compare_out_o      <= 1'b0;
			compare_out_oe_n_o <= 1'b1;
			compare_irq_flag_o <= 1'b0;
			fault_flag_o       <= 1'b0;
		end else begin
			fa_s1_q    <= fault_in_a_i;
			fa_s2_q    <= fa_s1_q;
			fb_s1_q    <= fault_in_b_i;
			fb_s2_q    <= fb_s1_q;
			flt_prev_q <= flt_lvl;
			if (hit(addr_i, `OCMP_ADDR_TCTL, wr_i))
				run_q <= wdata_i[1:0];
			last_cnt_q <= cnt;
			last_ok_q  <= 1'b1;
			if (mode_q != `OCMP_MODE_OFF && cnt != 16'h0000)
				seen_q <= 1'b1;
			done_q <= done_d;
			pin_q  <= pin_d;
			if (is_pwm(mode_q) && wrap)
				pri_q <= sec_q;
			// Flag set wins over a software clear in the same cycle
			if (flt_set) begin
				fault_q            <= 1'b1;
				fault_flag_o       <= 1'b1;
				compare_irq_flag_o <= 1'b1;
			end else if (flag_d && !is_pwm(mode_q)) begin
				compare_irq_flag_o <= 1'b1;
			// A pending fault keeps the flag up until a mode rewrite made with the fault pin back high
			end else if (hit(addr_i, `OCMP_ADDR_STAT, wr_i) && wdata_i[0] && !fault_q) begin
				compare_irq_flag_o <= 1'b0;
			end
			if (ctrl_wr) begin
				mode_q     <= wdata_i[`OCMP_MODE_MSB:`OCMP_MODE_LSB];
				tsel_q     <= wdata_i[`OCMP_TSEL_BIT];
				done_q     <= 1'b0;
				seen_q     <= 1'b0;
				last_ok_q  <= 1'b0;
				// A rewrite only ends a fault once the fault pin is back high
				if (flt_lvl) begin
					fault_q      <= 1'b0;
					fault_flag_o <= 1'b0;
				end
				case (wdata_i[`OCMP_MODE_MSB:`OCMP_MODE_LSB])
					`OCMP_MODE_OS_HI:                      pin_q <= 1'b1;
					`OCMP_MODE_TOGGLE:                     pin_q <= pin_q;
					`OCMP_MODE_PWM, `OCMP_MODE_PWM_FLT:    pin_q <= (pri_q != 16'h0000);
					default:                               pin_q <= 1'b0;
				endcase
			end
			// Primary is read-only while PWM runs
			if (hit(addr_i, `OCMP_ADDR_PRI, wr_i) && !is_pwm(mode_q))
				pri_q <= wdata_i;
			if (hit(addr_i, `OCMP_ADDR_SEC, wr_i))
				sec_q <= wdata_i;
			armed_q <= (mode_q != `OCMP_MODE_OFF);
			if (mode_q == `OCMP_MODE_OFF) begin
				compare_out_o      <= gpio_level_i;
				compare_out_oe_n_o <= 1'b0;
			end else begin
				compare_out_o      <= pin_d;
				// Release in the same edge as the fault flag, not one cycle later
				compare_out_oe_n_o <= (mode_q == `OCMP_MODE_PWM_FLT) && (fault_q || flt_set);
			end
			rdata_o <= 16'h0000;
			if (rd_i) begin
				case (addr_i)
					`OCMP_ADDR_CTRL: rdata_o <= {11'h000, fault_q, tsel_q, mode_q};
					`OCMP_ADDR_PRI:  rdata_o <= pri_q;
					`OCMP_ADDR_SEC:  rdata_o <= sec_q;
					`OCMP_ADDR_PER2: rdata_o <= per2;
					`OCMP_ADDR_PER3: rdata_o <= per3;
					`OCMP_ADDR_TMR2: rdata_o <= cnt2;
					`OCMP_ADDR_TMR3: rdata_o <= cnt3;
					`OCMP_ADDR_STAT: rdata_o <= {12'h000, armed_q, pin_q, fault_q,
						compare_irq_flag_o};
					`OCMP_ADDR_TCTL: rdata_o <= {14'h0000, run_q};
					default:         rdata_o <= 16'h0000;
				endcase
			end
		end
	end
endmodule // ocmp_unit

// ### test/ocmp_unit_chk.sv
// Port checker for the output compare unit
`timescale 1ns/1ps
`include "ocmp_defs.vh"
module ocmp_unit_chk (
	input wire logic        clock_i,
	input wire logic        rst_i,
	input wire logic [3:0]  addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [15:0] rdata_o,
	input wire logic        fault_in_a_i,
	input wire logic        fault_in_b_i,
	input wire logic        gpio_level_i,
	input wire logic        compare_out_o,
	input wire logic        compare_out_oe_n_o,
	input wire logic        compare_irq_flag_o,
	input wire logic        fault_flag_o
);
	logic [2:0] mode_q;
	logic       wctl;
	// Shadow of the mode field; events are judged against the mode in force
	assign wctl = wr_i && addr_i == `OCMP_ADDR_CTRL;
	always_ff @(posedge clock_i) begin
		if (rst_i)
			mode_q <= 3'h0;
		else if (wctl)
			mode_q <= wdata_i[2:0];
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	// Entry checks assume the timer is stopped across control writes
	a_lo_entry: assert property (wctl && wdata_i[2:0] == 3'h1
		|-> ##2 !compare_out_o && !compare_out_oe_n_o) else $error("Low start missing");
	a_hi_entry: assert property (wctl && wdata_i[2:0] == 3'h2
		|-> ##2 compare_out_o && !compare_out_oe_n_o) else $error("High start missing");
	a_delay_entry: assert property (wctl && wdata_i[2:1] == 2'h2
		|-> ##2 !compare_out_o) else $error("Pulse modes not starting low");
	a_toggle_keep: assert property (wctl && wdata_i[2:0] == 3'h3
		|-> ##2 compare_out_o == $past(compare_out_o, 2)) else $error("Toggle entry moved pin");
	a_lo_flag: assert property (mode_q == 3'h1 && $rose(compare_irq_flag_o)
		|-> $rose(compare_out_o)) else $error("Flag without rising pin");
	a_hi_flag: assert property (mode_q == 3'h2 && $rose(compare_irq_flag_o)
		|-> $fell(compare_out_o)) else $error("Flag without falling pin");
	a_fall_flag: assert property (mode_q[2:1] == 2'h2 && $rose(compare_irq_flag_o)
		|-> $fell(compare_out_o)) else $error("Pulse flag not on fall");
	a_toggle_flag: assert property (mode_q == 3'h3 && $changed(compare_out_o)
		|-> compare_irq_flag_o) else $error("Toggle edge without flag");
	a_quiet_modes: assert property (mode_q == 3'h0 || mode_q == 3'h6
		|-> !$rose(compare_irq_flag_o)) else $error("Flag raised in quiet mode");
	a_fault_hold: assert property (mode_q == 3'h7 && fault_flag_o
		|-> compare_out_oe_n_o && compare_irq_flag_o) else $error("Fault not holding");
	a_fault_src: assert property ($rose(fault_flag_o)
		|-> mode_q == 3'h7) else $error("Fault flag outside fault mode");
	cover property (mode_q == 3'h1 && $rose(compare_irq_flag_o));
	cover property (mode_q == 3'h3 && $changed(compare_out_o));
	cover property ($rose(fault_flag_o));
endmodule // ocmp_unit_chk

// ### test/ocmp_pin_model.sv
// Far side model: fault lines with pull-ups, output pin with pull-down
`timescale 1ns/1ps
module ocmp_pin_model (
	input  wire logic fa_low_i,
	input  wire logic fb_low_i,
	input  wire logic out_i,
	input  wire logic oe_n_i,
	output wire logic fault_in_a_o,
	output wire logic fault_in_b_o,
	output wire logic pin_o
);
	assign fault_in_a_o = !fa_low_i;
	assign fault_in_b_o = !fb_low_i;
	// A released pin falls to the board pull-down, not the last level
	assign pin_o = oe_n_i ? 1'b0 : out_i;
endmodule // ocmp_pin_model

// ### test/tb_top.sv
// Self-checking bench for the output compare unit
`timescale 1ns/1ps
`include "ocmp_defs.vh"
module tb_top;
	logic        clock_i, rst_i, wr_i, rd_i, gpio_level_i, fa_low, fb_low;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i;
	wire  [15:0] rdata_o;
	wire         fault_in_a_i, fault_in_b_i, compare_out_o, compare_out_oe_n_o;
	wire         compare_irq_flag_o, fault_flag_o, pin;
	int          mismatches, tests_run, cyc;
	ocmp_unit dut_u (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.fault_in_a_i, .fault_in_b_i, .gpio_level_i, .compare_out_o, .compare_out_oe_n_o,
		.compare_irq_flag_o, .fault_flag_o);
	ocmp_pin_model far_u (.fa_low_i(fa_low), .fb_low_i(fb_low), .out_i(compare_out_o),
		.oe_n_i(compare_out_oe_n_o), .fault_in_a_o(fault_in_a_i),
		.fault_in_b_o(fault_in_b_i), .pin_o(pin));
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 6000) begin
			mismatches++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("Compares %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	// An x expectation marks a level that the scenario leaves open
	task automatic cb(input string n, input logic s, input logic e);
		if (e !== 1'bx)
			chk(n, {15'h0000, s}, {15'h0000, e});
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e, input string n);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		chk(n, rdata_o, e);
	endtask
	task automatic run(input logic [15:0] t, input int n);
		wr(`OCMP_ADDR_TCTL, t);
		repeat (n) begin
			@(negedge clock_i);
			if (compare_irq_flag_o === 1'b1)
				break;
		end
		wr(`OCMP_ADDR_TCTL, 16'h0000);
		@(negedge clock_i);
	endtask
	task automatic go(input logic [15:0] m, p, s, input logic e0, e1, f);
		wr(`OCMP_ADDR_PRI, p);
		wr(`OCMP_ADDR_SEC, s);
		wr(`OCMP_ADDR_CTRL, m);
		wr(`OCMP_ADDR_STAT, 16'h0001);
		@(negedge clock_i);
		cb("entry pin", compare_out_o, e0);
		run(m[3] ? 16'h0002 : 16'h0001, 60);
		cb("flag", compare_irq_flag_o, f);
		cb("end pin", compare_out_o, e1);
		$display("Mode %h done", m);
	endtask
	initial begin
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		gpio_level_i = 1'b0;
		fa_low = 1'b0;
		fb_low = 1'b0;
		addr_i = 4'h0;
		wdata_i = 16'h0000;
		repeat (2) @(posedge clock_i);
		rst_i <= 1'b0;
		rd(`OCMP_ADDR_CTRL, `OCMP_CTRL_RST, "ctrl");
		rd(`OCMP_ADDR_PER2, `OCMP_PER_RST, "period");
		rd(4'hF, 16'h0000, "unmapped");
		cb("oe_n", compare_out_oe_n_o, 1'b0);
		wr(`OCMP_ADDR_PRI, 16'hA5C3);
		wr(`OCMP_ADDR_SEC, 16'h5A3C);
		rd(`OCMP_ADDR_PRI, 16'hA5C3, "primary");
		rd(`OCMP_ADDR_SEC, 16'h5A3C, "secondary");
		wr(`OCMP_ADDR_PER2, 16'h0013);
		wr(`OCMP_ADDR_PER3, 16'h0013);
		rd(`OCMP_ADDR_PER3, 16'h0013, "period3");
		$display("Register test done");
		go(16'h0001, 16'h0005, 16'h0000, 1'b0, 1'b1, 1'b1);
		go(16'h0002, 16'h0005, 16'h0000, 1'b1, 1'b0, 1'b1);
		go(16'h000B, 16'h0007, 16'h0000, 1'b0, 1'b1, 1'b1);
		go(16'h000B, 16'h0007, 16'h0000, 1'b1, 1'b0, 1'b1);
		go(16'h0004, 16'h0003, 16'h0006, 1'b0, 1'b0, 1'b1);
		wr(`OCMP_ADDR_STAT, 16'h0001);
		run(16'h0001, 45);
		cb("halted flag", compare_irq_flag_o, 1'b0);
		go(16'h0005, 16'h0003, 16'h0006, 1'b0, 1'b0, 1'b1);
		wr(`OCMP_ADDR_STAT, 16'h0001);
		run(16'h0001, 45);
		cb("repeat flag", compare_irq_flag_o, 1'b1);
		go(16'h0006, 16'h0005, 16'h0008, 1'b1, 1'bx, 1'b0);
		wr(`OCMP_ADDR_CTRL, 16'h0000);
		go(16'h0006, 16'h0000, 16'h0000, 1'b0, 1'b0, 1'b0);
		@(posedge clock_i);
		gpio_level_i <= 1'b1;
		go(16'h0000, 16'h0005, 16'h0008, 1'b1, 1'b1, 1'b0);
		go(16'h0007, 16'h0005, 16'h0008, 1'b1, 1'bx, 1'b0);
		@(posedge clock_i);
		fb_low <= 1'b1;
		repeat (8) @(negedge clock_i);
		cb("other fault", fault_flag_o, 1'b0);
		@(posedge clock_i);
		fa_low <= 1'b1;
		repeat (8) @(negedge clock_i);
		cb("fault", fault_flag_o, 1'b1);
		cb("fault irq", compare_irq_flag_o, 1'b1);
		cb("fault pin", pin, 1'b0);
		cb("fault oe", compare_out_oe_n_o, 1'b1);
		@(posedge clock_i);
		fa_low <= 1'b0;
		fb_low <= 1'b0;
		repeat (4) @(posedge clock_i);
		wr(`OCMP_ADDR_CTRL, 16'h0007);
		repeat (2) @(negedge clock_i);
		cb("fault clear", fault_flag_o, 1'b0);
		cb("drive again", compare_out_oe_n_o, 1'b0);
		$display("Fault test done");
		give_verdict();
	end
endmodule // tb_top
bind ocmp_unit ocmp_unit_chk chk_u (.clock_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
	.rdata_o, .fault_in_a_i, .fault_in_b_i, .gpio_level_i, .compare_out_o,
	.compare_out_oe_n_o, .compare_irq_flag_o, .fault_flag_o);
